// file: logic/rate_core_pkg.sv
/*
  Shared constants of the rate sensor processing and control core: register
  byte addresses, field positions, masks, reset values, timing and states.
  Assumes a 250 MHz system clock.
*/
`default_nettype none
package rate_core_pkg;
  // Clock rate and documented times in their own units.
  localparam int CLK_HZ = 250_000_000;
  localparam int BASE_SPS = 2429;
  localparam int FLASH_MS = 40;
  localparam int SLEEP_MS_PER_LSB = 500;
  // Cycle counts derived from the times above.
  localparam int SAMPLE_CYCLES = CLK_HZ / BASE_SPS;
  localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
  localparam int SLEEP_CYCLES = CLK_HZ / 1000 * SLEEP_MS_PER_LSB;
  localparam int CNT_W = 27;

  // Register byte addresses (low byte of each 16-bit register).
  localparam logic [6:0] ADDR_OFFSET = 7'h14;
  localparam logic [6:0] ADDR_SCALE = 7'h16;
  localparam logic [6:0] ADDR_GPIO = 7'h32;
  localparam logic [6:0] ADDR_DECIM = 7'h36;
  localparam logic [6:0] ADDR_FILT = 7'h38;
  localparam logic [6:0] ADDR_SLEEP = 7'h3A;
  localparam logic [6:0] ADDR_CMD = 7'h3E;

  // Implemented bits and reset values.
  localparam logic [15:0] MASK_OFFSET = 16'h0FFF;
  localparam logic [15:0] MASK_SCALE = 16'h0FFF;
  localparam logic [15:0] MASK_GPIO = 16'h0303;
  localparam logic [15:0] MASK_DECIM = 16'h000F;
  localparam logic [15:0] MASK_FILT = 16'h0707;
  localparam logic [15:0] MASK_SLEEP = 16'h00FF;
  localparam logic [15:0] MASK_CMD = 16'h008F;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_SCALE = 16'h0800;
  localparam logic [15:0] RST_GPIO = 16'h0000;
  localparam logic [15:0] RST_DECIM = 16'h0000;
  localparam logic [15:0] RST_FILT = 16'h0401;

  // Field positions.
  localparam int WR_FLAG = 15;
  localparam int RANGE_LSB = 8;
  localparam int LEVEL_LSB = 8;
  localparam int CMD_NULL = 0;
  localparam int CMD_FACTORY = 1;
  localparam int CMD_DAC = 2;
  localparam int CMD_FLASH = 3;
  localparam int CMD_SWRST = 7;

  // Range codes and the least tap exponent each one allows.
  localparam logic [2:0] RANGE_WIDE = 3'h4;
  localparam logic [2:0] RANGE_MID = 3'h2;
  localparam logic [2:0] RANGE_NARROW = 3'h1;
  localparam logic [2:0] MIN_WIDE = 3'h1;
  localparam logic [2:0] MIN_MID = 3'h2;
  localparam logic [2:0] MIN_NARROW = 3'h4;

  // Datapath sizes and calibration fixed point.
  localparam int DW = 14;
  localparam int RING = 128;
  localparam logic [11:0] SCALE_UNITY = 12'h800;
  localparam int CAL_SHIFT = 13;
  localparam int FLASH_REGS = 5;

  typedef enum logic [1:0] {ST_RUN, ST_RELOAD} core_state_type;
endpackage : rate_core_pkg
`default_nettype wire

// file: logic/spi_word_if.sv
/*
  Carrier between the serial link slave and the core. The link side drives
  the received word and its toggle; the core side drives the reply word.
  Assumes the reply word is stable whenever a frame is in progress.
*/
`timescale 1ns/10ps
`default_nettype none
interface spi_word_if;
  logic [15:0] word;
  logic word_tgl;
  logic [15:0] rd_word;
  modport link (output word, output word_tgl, input rd_word);
  modport core (input word, input word_tgl, output rd_word);
endinterface : spi_word_if
`default_nettype wire

// file: logic/spi_link_slave.sv
/*
  Serial link slave, clocked by the host's serial clock (idle high, data
  sampled on the rising edge, changed on the falling edge). Assumes the
  serial clock stands still outside frames and chip select frames them.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_link_slave (
  input wire logic sclk, // Serial clock from the host.
  input wire logic rst_n, // Core reset, asynchronous.
  input wire logic cs_n, // Chip select, active low.
  input wire logic mosi, // Serial data in.
  output logic miso, // Serial data out.
  output logic miso_oe, // Drive enable of the data out pin.
  spi_word_if.link lnk // Word towards the core.
);
  logic [3:0] rise_q;
  logic [3:0] fall_q;
  logic [14:0] shift_q;

  // Bit count restarts with every frame, so a short frame leaves no trace.
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      rise_q <= 4'h0;
    else
      rise_q <= rise_q + 4'h1;
  end

  // Incoming bits, most significant first.
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
      shift_q <= 15'h0000;
    else
      shift_q <= {shift_q[13:0], mosi};
  end

  // The sixteenth bit completes a byte-wide access frame.
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lnk.word <= 16'h0000;
      lnk.word_tgl <= 1'b0;
    end
    else if (rise_q == 4'hF)
    begin
      lnk.word <= {shift_q, mosi};
      lnk.word_tgl <= ~lnk.word_tgl;
    end
  end

  // Outgoing bit index advances on each falling edge.
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      fall_q <= 4'h0;
    else
      fall_q <= fall_q + 4'h1;
  end

  // The reply word is held still by the core across the frame. Bit 15 must
  // stand after the first falling edge, so the index is sixteen minus the
  // count, which wraps to bit 0 on the last falling edge.
  assign miso = lnk.rd_word[4'h0 - fall_q];
  assign miso_oe = ~cs_n;
endmodule : spi_link_slave
`default_nettype wire

// file: logic/rate_core.sv
/*
  Rate sensor processing and control core: decimation, two-stage averaging
  filter, range and tap limits, user calibration, command triggers, flash
  mirror, sleep timer and general lines. Assumes raw samples arrive on the
  system clock and the host reaches registers over the serial link.
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Output updates at 2429 samples per second without decimation.
// - Update rate is base rate divided by two to the power D.
// - Decimation averages all samples within each interval.
// - Filter is two equal cascaded moving averages, a triangular response.
// - Each stage length is two to the power of the tap field.
// - Range codes 100, 010, 001 select 14000, 7000, 3500 degrees per second.
// - Tap field is raised to 1, 2 or 4 by range.
// - Signed 12-bit offset added in quarter output steps.
// - Offset-binary 12-bit scale, 0x800 unity, zero gives zero.
// - Command bits set by writing one, cleared on completion.
// - Bit 7 halts sensing and replays start-up.
// - Start-up reloads flash-backed registers before new data.
// - Bits 3, 2, 1, 0: flash backup, DAC latch, factory restore, null.
// - Sleep lasts written count times half a second.
// - Line function priority: misc control, alarm control, general control.
// - Direction bits 1 and 0 make lines two and one outputs.
// - Level bits 9 and 8 drive lines configured as outputs.
// - Access is bytewise, low address bits 7:0, high bits 15:8.
// - Flash backup copies mirrored registers and takes 40 ms.
module rate_core
  import rate_core_pkg::*;
#(
  parameter int SAMPLE_P = rate_core_pkg::SAMPLE_CYCLES,
  parameter int FLASH_P = rate_core_pkg::FLASH_CYCLES,
  parameter int SLEEP_P = rate_core_pkg::SLEEP_CYCLES
) (
  input wire logic clk, // System clock, 250 MHz.
  input wire logic nrst, // Reset, active low, asynchronous.
  input wire logic sclk, // Serial clock from the host.
  input wire logic cs_n, // Serial chip select, active low.
  input wire logic mosi, // Serial data in.
  output logic miso, // Serial data out.
  output logic miso_oe, // Drive enable of serial data out.
  input wire logic [rate_core_pkg::DW-1:0] raw_rate, // Converter sample.
  output logic [15:0] rate_out, // Processed rate, sign extended.
  output logic data_ready, // Pulse with each new rate_out.
  output logic sleeping, // High while asleep.
  output logic autonull_go, // Pulse, bias null request.
  output logic cal_restore_go, // Pulse, factory restore request.
  output logic dac_latch_go, // Pulse, DAC latch request.
  output logic [2:0] range_sel, // Active measurement range code.
  input wire logic [1:0] misc_claim, // Misc control owns the line.
  input wire logic [1:0] misc_level, // Level misc control drives.
  input wire logic [1:0] alarm_claim, // Alarm control owns the line.
  input wire logic [1:0] alarm_level, // Level alarm control drives.
  input wire logic [1:0] line_in, // General line pin levels.
  output logic [1:0] line_out, // General line drive levels.
  output logic [1:0] line_oe // General line drive enables.
);
  import rate_core_pkg::*;

  spi_word_if bus ();
  logic [1:0] rst_q;
  logic rst_n;
  logic [2:0] tgl_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_q;
  logic word_ev;
  logic wr_ev;
  logic [6:0] w_addr;
  logic [7:0] w_data;
  logic [15:0] off_q, scale_q, gpio_q, decim_q, filt_q;
  logic [7:0] sleep_q;
  logic [7:0] cmd_q;
  logic [7:0] cmd_set;
  logic [7:0] cmd_done;
  logic [15:0] flash_q [FLASH_REGS];
  core_state_type state_q;
  logic [CNT_W-1:0] smp_cnt_q, fl_cnt_q, slp_cyc_q;
  logic [7:0] slp_rem_q;
  logic fl_done;
  logic tick;
  logic flush;
  logic [2:0] tap_m;
  logic [6:0] tap_n;
  logic signed [DW-1:0] stage_in [3];
  logic vld [3];
  logic signed [28:0] dec_acc_q;
  logic [14:0] dec_cnt_q;
  logic dec_last;
  logic signed [DW-1:0] dec_q;
  logic dec_vld_q;
  logic signed [17:0] cal_t;
  logic signed [30:0] cal_p;
  logic signed [17:0] cal_s;
  logic [15:0] rd_mux;
  logic [1:0] level_rd;

  // Byte merge keeps the other half of the register untouched.
  function automatic logic [15:0] merge(input logic [15:0] old,
    input logic hi, input logic [7:0] d, input logic [15:0] mask);
    merge = (hi ? {d, old[7:0]} : {old[15:8], d}) & mask;
  endfunction : merge

  // Raises the tap exponent to the least that the range allows.
  function automatic logic [15:0] clamp_filt(input logic [15:0] v);
    logic [2:0] lo;
    lo = MIN_WIDE;
    case (v[RANGE_LSB+:3])
      RANGE_MID: lo = MIN_MID;
      RANGE_NARROW: lo = MIN_NARROW;
      default: lo = MIN_WIDE;
    endcase
    clamp_filt = (v[2:0] < lo) ? {v[15:3], lo} : v;
  endfunction : clamp_filt

  // Reset is released through two flip-flops.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  spi_link_slave u_link (
    .sclk(sclk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .lnk(bus.link)
  );

  // Frame toggle and pin levels cross through two flip-flops each.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_q <= 3'b000;
      pin_s1_q <= 2'b00;
      pin_q <= 2'b00;
    end
    else
    begin
      tgl_q <= {tgl_q[1:0], bus.word_tgl};
      pin_s1_q <= line_in;
      pin_q <= pin_s1_q;
    end
  end

  // The word is stable long before its toggle is seen here.
  assign word_ev = tgl_q[2] ^ tgl_q[1];
  assign wr_ev = word_ev & bus.word[WR_FLAG] & (state_q == ST_RUN);
  assign w_addr = bus.word[14:8];
  assign w_data = bus.word[7:0];

  // Register file; a software reset reloads the flash copies.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      off_q <= RST_OFFSET;
      scale_q <= RST_SCALE;
      gpio_q <= RST_GPIO;
      decim_q <= RST_DECIM;
      filt_q <= RST_FILT;
      sleep_q <= 8'h00;
    end
    else if (state_q == ST_RELOAD)
    begin
      off_q <= flash_q[0];
      scale_q <= flash_q[1];
      gpio_q <= flash_q[2];
      decim_q <= flash_q[3];
      filt_q <= flash_q[4];
      sleep_q <= 8'h00;
    end
    else if (wr_ev)
    begin
      case ({w_addr[6:1], 1'b0})
        ADDR_OFFSET: off_q <= merge(off_q, w_addr[0], w_data, MASK_OFFSET);
        ADDR_SCALE: scale_q <= merge(scale_q, w_addr[0], w_data, MASK_SCALE);
        ADDR_GPIO: gpio_q <= merge(gpio_q, w_addr[0], w_data, MASK_GPIO);
        ADDR_DECIM: decim_q <= merge(decim_q, w_addr[0], w_data, MASK_DECIM);
        ADDR_FILT: filt_q <= clamp_filt(merge(filt_q, w_addr[0], w_data,
          MASK_FILT));
        ADDR_SLEEP: sleep_q <= w_addr[0] ? sleep_q : w_data;
        default: ;
      endcase
    end
  end

  // Trigger bits: a new set wins over a completion in the same cycle.
  assign cmd_set = (wr_ev && w_addr == ADDR_CMD) ?
    (w_data & MASK_CMD[7:0]) : 8'h00;
  always_comb
  begin
    cmd_done = 8'h00;
    cmd_done[CMD_NULL] = cmd_q[CMD_NULL];
    cmd_done[CMD_FACTORY] = cmd_q[CMD_FACTORY];
    cmd_done[CMD_DAC] = cmd_q[CMD_DAC];
    cmd_done[CMD_FLASH] = fl_done;
    cmd_done[CMD_SWRST] = (state_q == ST_RELOAD);
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_q <= 8'h00;
    else
      cmd_q <= (cmd_q & ~cmd_done) | cmd_set;
  end
  assign autonull_go = cmd_q[CMD_NULL];
  assign cal_restore_go = cmd_q[CMD_FACTORY];
  assign dac_latch_go = cmd_q[CMD_DAC];

  // Flash mirror: snapshot at the start, busy for the whole write time.
  assign fl_done = cmd_q[CMD_FLASH] &&
    (fl_cnt_q == CNT_W'(FLASH_P - 1));
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fl_cnt_q <= '0;
      flash_q[0] <= RST_OFFSET;
      flash_q[1] <= RST_SCALE;
      flash_q[2] <= RST_GPIO;
      flash_q[3] <= RST_DECIM;
      flash_q[4] <= RST_FILT;
    end
    else
    begin
      fl_cnt_q <= (cmd_q[CMD_FLASH] && !fl_done) ? fl_cnt_q + 1'b1 : '0;
      if (cmd_set[CMD_FLASH] && !cmd_q[CMD_FLASH])
      begin
        flash_q[0] <= off_q;
        flash_q[1] <= scale_q;
        flash_q[2] <= gpio_q;
        flash_q[3] <= decim_q;
        flash_q[4] <= filt_q;
      end
    end
  end

  // Software reset halts sensing for one reload cycle, then runs again.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_RUN;
    else
    begin
      case (state_q)
        ST_RUN: if (cmd_q[CMD_SWRST]) state_q <= ST_RELOAD;
        ST_RELOAD: state_q <= ST_RUN;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Sleep counts half seconds; a zero write wakes at once.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slp_rem_q <= 8'h00;
      slp_cyc_q <= '0;
    end
    else if (state_q == ST_RELOAD)
    begin
      slp_rem_q <= 8'h00;
      slp_cyc_q <= '0;
    end
    else if (wr_ev && w_addr == ADDR_SLEEP)
    begin
      slp_rem_q <= w_data;
      slp_cyc_q <= '0;
    end
    else if (sleeping)
    begin
      slp_cyc_q <= (slp_cyc_q == CNT_W'(SLEEP_P - 1)) ? '0 : slp_cyc_q + 1'b1;
      if (slp_cyc_q == CNT_W'(SLEEP_P - 1))
        slp_rem_q <= slp_rem_q - 8'h01;
    end
  end
  assign sleeping = (slp_rem_q != 8'h00);

  // Base sample timer; no samples are taken while asleep or reloading.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      smp_cnt_q <= '0;
    else if (smp_cnt_q == CNT_W'(SAMPLE_P - 1))
      smp_cnt_q <= '0;
    else
      smp_cnt_q <= smp_cnt_q + 1'b1;
  end
  assign tick = (smp_cnt_q == CNT_W'(SAMPLE_P - 1)) && !sleeping &&
    (state_q == ST_RUN);

  // Changing filter or decimation restarts the averages from zero.
  assign flush = (state_q == ST_RELOAD) || (wr_ev &&
    ({w_addr[6:1], 1'b0} == ADDR_FILT || {w_addr[6:1], 1'b0} == ADDR_DECIM));
  assign tap_m = filt_q[2:0];
  assign tap_n = 7'(8'h01 << tap_m);
  assign range_sel = filt_q[RANGE_LSB+:3];
  assign stage_in[0] = raw_rate;
  assign vld[0] = tick;

  // Two equal running-sum stages; a 128-tap stage reads the slot it
  // overwrites, which is why the read precedes the write.
  for (genvar k = 0; k < 2; k++)
  begin : g_stage
    logic signed [DW-1:0] ring_q [RING];
    logic [6:0] wr_q;
    logic [6:0] rd_idx;
    logic signed [20:0] sum_q;
    logic vld_q;
    assign rd_idx = wr_q - tap_n;
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        wr_q <= 7'h00;
        sum_q <= '0;
        vld_q <= 1'b0;
        for (int i = 0; i < RING; i++) ring_q[i] <= '0;
      end
      else
      begin
        vld_q <= vld[k] && !flush;
        if (flush)
        begin
          wr_q <= 7'h00;
          sum_q <= '0;
          for (int i = 0; i < RING; i++) ring_q[i] <= '0;
        end
        else if (vld[k])
        begin
          sum_q <= sum_q + 21'(stage_in[k]) - 21'(ring_q[rd_idx]);
          ring_q[wr_q] <= stage_in[k];
          wr_q <= wr_q + 7'h01;
        end
      end
    end
    assign stage_in[k+1] = DW'(sum_q >>> tap_m);
    assign vld[k+1] = vld_q;
  end

  // Decimation averages every sample of an interval.
  assign dec_last = (dec_cnt_q == 15'((16'h0001 << decim_q[3:0]) - 16'h0001));
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dec_acc_q <= '0;
      dec_cnt_q <= 15'h0000;
      dec_q <= '0;
      dec_vld_q <= 1'b0;
    end
    else
    begin
      dec_vld_q <= vld[2] && dec_last && !flush;
      if (flush)
      begin
        dec_acc_q <= '0;
        dec_cnt_q <= 15'h0000;
      end
      else if (vld[2])
      begin
        dec_acc_q <= dec_last ? '0 : dec_acc_q + 29'(stage_in[2]);
        dec_cnt_q <= dec_last ? 15'h0000 : dec_cnt_q + 15'h0001;
        if (dec_last)
          dec_q <= DW'((dec_acc_q + 29'(stage_in[2])) >>> decim_q[3:0]);
      end
    end
  end

  // Offset in quarter steps, then scale with 0x800 as unity.
  assign cal_t = {{2{dec_q[DW-1]}}, dec_q, 2'b00} +
    {{6{off_q[11]}}, off_q[11:0]};
  assign cal_p = cal_t * $signed({1'b0, scale_q[11:0]});
  assign cal_s = 18'(cal_p >>> CAL_SHIFT);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_out <= 16'h0000;
      data_ready <= 1'b0;
    end
    else
    begin
      data_ready <= dec_vld_q && (state_q == ST_RUN);
      if (dec_vld_q)
      begin
        // Saturate rather than wrap so a large trim cannot flip the sign.
        if (cal_s > 18'sd8191)
          rate_out <= 16'h1FFF;
        else if (cal_s < -18'sd8192)
          rate_out <= 16'hE000;
        else
          rate_out <= 16'(cal_s);
      end
    end
  end

  // Lines: misc control, then alarm control, then general control.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (misc_claim[i])
      begin
        line_out[i] = misc_level[i];
        line_oe[i] = 1'b1;
      end
      else if (alarm_claim[i])
      begin
        line_out[i] = alarm_level[i];
        line_oe[i] = 1'b1;
      end
      else
      begin
        line_out[i] = gpio_q[LEVEL_LSB+i];
        line_oe[i] = gpio_q[i];
      end
      level_rd[i] = gpio_q[i] ? gpio_q[LEVEL_LSB+i] : pin_q[i];
    end
  end

  // Read mux returns the whole word holding the addressed byte.
  always_comb
  begin
    case ({w_addr[6:1], 1'b0})
      ADDR_OFFSET: rd_mux = off_q;
      ADDR_SCALE: rd_mux = scale_q;
      ADDR_GPIO: rd_mux = {6'h00, level_rd, 6'h00, gpio_q[1:0]};
      ADDR_DECIM: rd_mux = decim_q;
      ADDR_FILT: rd_mux = filt_q;
      ADDR_SLEEP: rd_mux = {8'h00, sleep_q};
      ADDR_CMD: rd_mux = {8'h00, cmd_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Reply is loaded after a read frame and shifted out in the next one.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.rd_word <= 16'h0000;
    else if (word_ev && !bus.word[WR_FLAG])
      bus.rd_word <= rd_mux;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_TICK_PERIOD: assert property (
    tick |-> smp_cnt_q == CNT_W'(SAMPLE_P - 1))
    else $error("sample tick off period");
  AST_DECIM_HOLD: assert property (
    vld[2] && !dec_last |=> !dec_vld_q)
    else $error("decimator emitted early");
  AST_FILT_MIN: assert property (
    filt_q[RANGE_LSB+:3] == RANGE_NARROW |-> filt_q[2:0] >= MIN_NARROW)
    else $error("narrow range tap limit broken");
  AST_SCALE_UNITY: assert property (
    dec_vld_q && scale_q[11:0] == SCALE_UNITY && off_q[11:0] == 12'h000
    |=> rate_out == 16'($past(dec_q)))
    else $error("unity scale changed data");
  AST_SCALE_ZERO: assert property (
    dec_vld_q && scale_q[11:0] == 12'h000 |=> rate_out == 16'h0000)
    else $error("zero scale gave nonzero");
  AST_CMD_CLEAR: assert property (
    cmd_q[CMD_DAC] && !cmd_set[CMD_DAC] |=> !cmd_q[CMD_DAC])
    else $error("trigger did not clear");
  AST_SWRST: assert property (
    cmd_q[CMD_SWRST] && state_q == ST_RUN |=> state_q == ST_RELOAD
    ##1 !cmd_q[CMD_SWRST] && state_q == ST_RUN)
    else $error("software reset sequence wrong");
  AST_RELOAD: assert property (
    state_q == ST_RELOAD |=> filt_q == $past(flash_q[4]) && !data_ready)
    else $error("reload missed flash copy");
  AST_SLEEP: assert property (
    wr_ev && w_addr == ADDR_SLEEP && w_data != 8'h00 |=> sleeping && !tick)
    else $error("sleep not entered");
  AST_FLASH_TIME: assert property (
    fl_done |-> cmd_q[CMD_FLASH] && fl_cnt_q == CNT_W'(FLASH_P - 1))
    else $error("flash backup time wrong");
  AST_LINE_PRIO: assert property (
    misc_claim[1] |-> line_oe[1] && line_out[1] == misc_level[1])
    else $error("misc control lost priority");
  AST_LINE_OUT: assert property (
    !misc_claim[0] && !alarm_claim[0] && gpio_q[0]
    |-> line_oe[0] && line_out[0] == gpio_q[LEVEL_LSB])
    else $error("general output level wrong");
endmodule : rate_core
`default_nettype wire

// file: tb/spi_host.sv
/*
  Serial host model: 16-bit frames, clock idle high, data set on the falling
  edge and taken on the rising edge. Assumes a 48 ns serial period.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_host (
  output logic sclk, // Serial clock, idle high.
  output logic cs_n, // Chip select, active low.
  output logic mosi, // Serial data to device.
  input wire logic miso, // Serial data from device.
  input wire logic miso_oe // Device drives miso.
);
  // Idle levels; the clock stands still outside frames.
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame, MSB first: write flag, address, data byte.
  task xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      #24 sclk = 1'b0;
      mosi = w[i];
      #24 sclk = 1'b1;
      r[i] = miso_oe ? miso : 1'bx;
    end
    #24 cs_n = 1'b1;
    mosi = ~mosi; // A released line must not keep its last value.
    #200;
  endtask : xfer
endmodule : spi_host
`default_nettype wire

// file: tb/rate_sensor_processing_control_test.sv
/*
  Self-checking bench of rate_core with short timing parameters. Assumes
  the serial host model drives the link and random samples feed the core.
*/
`timescale 1ns/10ps
`default_nettype none
module rate_sensor_processing_control_test;
  import rate_core_pkg::*;
  logic clk = 0, nrst = 0, sclk, cs_n, mosi, miso, miso_oe;
  logic [DW-1:0] raw_rate = '0;
  logic [15:0] rate_out, r;
  logic data_ready, sleeping, nul, cal, dac, hold = 1'b0;
  logic [1:0] misc_claim = 2'b00, misc_level = 2'b00;
  logic [1:0] alarm_claim = 2'b00, alarm_level = 2'b00;
  logic [2:0] range_sel;
  logic [1:0] line_in = 2'b01, line_out, line_oe;
  logic [7:0] lfsr = 8'h61;
  int n_fail = 0, compares = 0, cyc = 0, n_rdy = 0, n_nul = 0;
  int n_cal = 0, n_dac = 0;
  // The core clock, 4 ns period.
  always #2 clk = ~clk;
  rate_core #(.SAMPLE_P(20), .FLASH_P(400), .SLEEP_P(200)) i_rate_core (
    .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .raw_rate(raw_rate),
    .rate_out(rate_out), .data_ready(data_ready), .sleeping(sleeping),
    .autonull_go(nul), .cal_restore_go(cal), .dac_latch_go(dac),
    .range_sel(range_sel), .misc_claim(misc_claim),
    .misc_level(misc_level), .alarm_claim(alarm_claim),
    .alarm_level(alarm_level), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe));
  spi_host i_spi_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));
  function automatic logic [7:0] step(input logic [7:0] v);
    step = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : step
  // Random samples change away from the sampling edge.
  always @(negedge clk)
  begin
    lfsr <= step(lfsr);
    raw_rate <= hold ? '0 : {{6{lfsr[7]}}, lfsr};
  end
  // Pulse counters and the hang limit.
  always @(posedge clk)
  begin
    cyc++;
    n_rdy += data_ready;
    n_nul += nul;
    n_cal += cal;
    n_dac += dac;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    if (seen !== exp)
      n_fail++;
  endtask : chk
  // Each byte is its own write frame.
  task wr(input logic [6:0] a, input logic [7:0] d);
    i_spi_host.xfer({1'b1, a, d}, r);
    repeat (10) @(negedge clk);
  endtask : wr
  // The reply of a read comes out during the following frame.
  task rd(input logic [6:0] a);
    i_spi_host.xfer({1'b0, a, 8'h00}, r);
    repeat (10) @(negedge clk);
    i_spi_host.xfer(16'h0000, r);
  endtask : rd
  task end_of_test;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    rd(ADDR_FILT);
    chk(r, 16'h0401);
    rd(ADDR_SCALE);
    chk(r, 16'h0800);
    // Range first, then a tap count below its floor.
    wr(ADDR_FILT | 7'h01, 8'h01);
    wr(ADDR_FILT, 8'h02);
    rd(ADDR_FILT);
    chk(r, 16'h0104);
    chk({13'h0000, range_sel}, 16'h0001);
    $display("range test done");
    wr(ADDR_GPIO | 7'h01, 8'h02);
    wr(ADDR_GPIO, 8'h02);
    chk({13'h0000, line_oe, line_out[1]}, 16'h0005);
    rd(ADDR_GPIO);
    chk(r, 16'h0302);
    // Misc control outranks the general bits on line two; alarm control outranks them on line one.
    @(negedge clk);
    misc_claim = 2'b10;
    alarm_claim = 2'b11;
    alarm_level = 2'b01;
    @(negedge clk);
    chk({12'h000, line_oe, line_out}, 16'h000D);
    misc_claim = 2'b00;
    alarm_claim = 2'b00;
    wr(ADDR_CMD, 8'h07);
    chk(16'(n_nul), 16'h0001);
    chk(16'(n_cal), 16'h0001);
    chk(16'(n_dac), 16'h0001);
    rd(ADDR_CMD);
    chk(r, 16'h0000);
    $display("line and command test done");
    n_rdy = 0;
    repeat (400) @(negedge clk);
    chk(16'(n_rdy), 16'h0014);
    // Zero input after a flush leaves only the offset, a quarter step each.
    hold = 1'b1;
    wr(ADDR_DECIM, 8'h02);
    wr(ADDR_OFFSET, 8'h10);
    repeat (100) @(negedge clk);
    n_rdy = 0;
    repeat (400) @(negedge clk);
    chk(16'(n_rdy), 16'h0005);
    chk(rate_out, 16'h0004);
    wr(ADDR_SCALE | 7'h01, 8'h00);
    repeat (100) @(negedge clk);
    chk(rate_out, 16'h0000);
    // Back up, then change a mirrored register so the reload shows the copy.
    wr(ADDR_CMD, 8'h08);
    rd(ADDR_CMD);
    chk(r, 16'h0008);
    rd(ADDR_CMD);
    chk(r, 16'h0000);
    wr(ADDR_DECIM, 8'h00);
    wr(ADDR_CMD, 8'h80);
    rd(ADDR_DECIM);
    chk(r, 16'h0002);
    wr(ADDR_SLEEP, 8'h02);
    chk({15'h0000, sleeping}, 16'h0001);
    repeat (400) @(negedge clk);
    chk({15'h0000, sleeping}, 16'h0000);
    $display("rate and sleep test done");
    end_of_test;
  end
endmodule : rate_sensor_processing_control_test
`default_nettype wire
